// [verilog/cws_pkg.sv]
// Package of the complementary waveform shutdown block: register map,
// field positions, reset values, timing counts and carrier structs.
// Assumes a 125 MHz system clock and 32-bit Avalon-MM register access.
package cws_pkg;

  // ********************************************
  // Register byte offsets
  // ********************************************
  localparam logic [4:0] OFS_MAIN_CTRL = 5'h00; // waveform_main_control
  localparam logic [4:0] OFS_SRC_OVR = 5'h04; // waveform_source_override
  localparam logic [4:0] OFS_SHDN_CTRL = 5'h08; // waveform_shutdown_control
  localparam logic [4:0] OFS_DB_RISE = 5'h0C; // rising_deadband_count
  localparam logic [4:0] OFS_DB_FALL = 5'h10; // falling_deadband_count

  // ********************************************
  // Field positions
  // ********************************************
  localparam int MC_ENABLE = 7; // module_enable
  localparam int MC_OE_B = 6; // out_b_pin_enable
  localparam int MC_OE_A = 5; // out_a_pin_enable
  localparam int MC_INV_B = 4; // out_b_invert
  localparam int MC_INV_A = 3; // out_a_invert
  localparam int MC_CLK_SEL = 0; // gen_clock_select
  localparam int SO_LVL_B = 6; // override_level_b low bit
  localparam int SO_LVL_A = 4; // override_level_a low bit
  localparam int SO_SRC = 0; // input_source_select low bit
  localparam int SC_EVENT = 7; // shutdown_event
  localparam int SC_AUTO = 6; // auto_restart_enable
  localparam int SC_CMP2 = 3; // shutdown_on_comparator2
  localparam int SC_CMP1 = 2; // shutdown_on_comparator1
  localparam int SC_FAULT = 1; // shutdown_on_fault_pin
  localparam int SC_LC2 = 0; // shutdown_on_logic_cell2

  // ********************************************
  // Reset values and writable masks
  // ********************************************
  localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
  localparam logic [7:0] RST_SRC_OVR = 8'h00;
  localparam logic [7:0] RST_SHDN_CTRL = 8'h00;
  localparam logic [5:0] RST_DB = 6'h00;
  localparam logic [7:0] MASK_MAIN_CTRL = 8'hF9;
  localparam logic [7:0] MASK_SRC_OVR = 8'hF7;
  localparam logic [7:0] MASK_SHDN_CTRL = 8'h4F;

  // ********************************************
  // Override level codes
  // ********************************************
  localparam logic [1:0] LVL_HIGH = 2'h3;
  localparam logic [1:0] LVL_LOW = 2'h2;
  localparam logic [1:0] LVL_TRI = 2'h1;
  localparam logic [1:0] LVL_INACTIVE = 2'h0;

  // ********************************************
  // Timing
  // ********************************************
  localparam int CLK_HZ = 125_000_000; // System clock rate
  localparam int HF_OSC_HZ = 16_000_000; // Internal oscillator rate
  localparam int HF_DIV = CLK_HZ / HF_OSC_HZ; // Cycles per oscillator tick

  // Selectable waveform sources
  typedef struct packed {
    logic logic_cell1_output;
    logic oscillator_output;
    logic [3:0] pwm_output; // PWM4..PWM1
    logic comparator2_output;
    logic comparator1_output;
  } cws_src_s;

  // Shutdown fault sources
  typedef struct packed {
    logic comparator2_output;
    logic comparator1_output;
    logic fault_input_pin_n; // Low means fault
    logic logic_cell2_output;
  } cws_fault_s;

endpackage : cws_pkg

// [verilog/cws_tick_divider.sv]
// Generator clock tick: every cycle, or a divided tick near the internal
// oscillator rate. Assumes the single 125 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module cws_tick_divider (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic use_hf_osc, // Select divided oscillator tick
  output logic tick // One-cycle generator tick
);

  // Divider counter
  logic [3:0] div_reg;

  // ********************************************
  // Divider
  // ********************************************
  // Free-running count, wraps at the oscillator period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= 4'h0;
    end else if (div_reg == 4'(cws_pkg::HF_DIV - 1)) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  assign tick = use_hf_osc ? (div_reg == 4'h0) : 1'b1;

endmodule : cws_tick_divider
`default_nettype wire

// [verilog/cws_deadband.sv]
// One dead-band delay: output follows a rising level only after a
// programmed number of generator ticks; drops at once when the level drops.
// Assumes level is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module cws_deadband (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic tick, // Generator clock tick
  input wire logic level, // Requested on level
  input wire logic [5:0] count, // Dead-band ticks
  output logic drive // Delayed on level
);

  // Ticks counted since the level rose
  logic [5:0] cnt_reg;

  // ********************************************
  // Counter
  // ********************************************
  // count up to value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 6'h00;
    end else if (!level) begin
      cnt_reg <= 6'h00;
    end else if (tick && cnt_reg < count) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // tick alignment uncertainty
  // A count lowered mid-interval must not force a wrap of the counter
  assign drive = level && (cnt_reg >= count);

  // ********************************************
  // Checks
  // ********************************************
  a_db_bypass: assert property (@(posedge clk) disable iff (reset)
    (level && count == 6'h00) |-> drive)
    else $error("zero dead band did not bypass");
  a_db_drop: assert property (@(posedge clk) disable iff (reset)
    !level |-> !drive)
    else $error("drive stayed on with level low");

endmodule : cws_deadband
`default_nettype wire

// [verilog/cws_top.sv]
// Complementary waveform generator with auto-shutdown, register file on
// Avalon-MM with waitrequest. Assumes all waveform and fault inputs are
// synchronous to clk and that an I/O port applies the pin enables.
//
// Functional notes
// - Software shutdown bit forces override levels
// - No auto-restart: shutdown holds while bit set
// - Auto-restart: software bit self-clears, restart
// - Enabled fault source forces overrides, sets bit
// - Sources sensed by level, hold shutdown
// - Bits 3,2 enable comparator shutdown
// - Bit 1 enables low fault pin shutdown
// - Bit 0 enables logic cell 2 shutdown
// - Override codes: one, zero, tristate, inactive
// - Software clear refused while source active
// - Overrides stay until next input rising edge
// - Auto-restart clears bit once sources inactive
// - Generator keeps running during sleep
// - Keep oscillator on when enabled and selected
// - Enable and per-output pin connect bits
// - Bits 4,3 invert outputs B and A
// - Bit 0 selects generator clock
// - Three-bit field selects input waveform
// - Control 2 event status and auto-restart
// - Dead band may vary one tick
// - Enabling starts with both drives cleared
// - Dead band counts ticks; zero bypasses
// - Disabled module leaves pins uncontrolled
`timescale 1ns/1ps
`default_nettype none
module cws_top (
  input wire logic clk, // System clock, 125 MHz
  input wire logic reset, // Async reset, high
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire cws_pkg::cws_src_s wave_src, // Selectable waveforms
  input wire cws_pkg::cws_fault_s fault_src, // Shutdown sources
  output logic output_a, // Pin A level
  output logic output_a_oe, // Pin A driven
  output logic output_b, // Pin B level
  output logic output_b_oe, // Pin B driven
  output logic hf_osc_keep_on // Keep oscillator in sleep
);

  // ********************************************
  // Declarations
  // ********************************************
  logic [7:0] main_ctrl_reg; // waveform_main_control
  logic [7:0] src_ovr_reg; // waveform_source_override
  logic [7:0] shdn_ctrl_reg; // Control 2 without event bit
  logic [5:0] db_rise_reg; // rising_deadband_count
  logic [5:0] db_fall_reg; // falling_deadband_count
  logic shutdown_event_reg; // shutdown_event status
  logic shut_state_reg; // Overrides applied
  logic wave_prev_reg; // Previous input sample
  logic ack_reg; // Bus answer phase
  logic [31:0] rdata_reg; // Read data
  logic wr_ok; // Accepted write
  logic wr_shdn; // Accepted control 2 write
  logic sw_set; // Software sets event
  logic sw_clear; // Software clears event
  logic src_active; // Any enabled source active
  logic shutdown_any; // Combined shutdown
  logic force_ovr; // Outputs overridden
  logic wave_sel; // Selected input waveform
  logic wave_rise; // Input rising edge
  logic gen_tick; // Generator tick
  logic module_enable; // Enable bit
  logic auto_restart_enable; // Auto-restart bit
  logic [1:0] override_level_a; // Override code A
  logic [1:0] override_level_b; // Override code B
  logic core_a; // Dead-banded A
  logic core_b; // Dead-banded B

  assign module_enable = main_ctrl_reg[cws_pkg::MC_ENABLE];
  assign auto_restart_enable = shdn_ctrl_reg[cws_pkg::SC_AUTO];
  assign override_level_a = src_ovr_reg[cws_pkg::SO_LVL_A +: 2];
  assign override_level_b = src_ovr_reg[cws_pkg::SO_LVL_B +: 2];

  // ********************************************
  // Avalon-MM slave
  // ********************************************
  // One wait cycle per access, then the answer cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_ok = avs_write && ack_reg && avs_byteenable[0];
  assign wr_shdn = wr_ok && avs_address == cws_pkg::OFS_SHDN_CTRL;
  assign sw_set = wr_shdn && avs_writedata[cws_pkg::SC_EVENT];
  assign sw_clear = wr_shdn && !avs_writedata[cws_pkg::SC_EVENT];

  // Read mux captured in the wait cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        cws_pkg::OFS_MAIN_CTRL: rdata_reg <= {24'h000000, main_ctrl_reg};
        cws_pkg::OFS_SRC_OVR: rdata_reg <= {24'h000000, src_ovr_reg};
        cws_pkg::OFS_SHDN_CTRL: rdata_reg <= {24'h000000, shutdown_event_reg, shdn_ctrl_reg[6:0]};
        cws_pkg::OFS_DB_RISE: rdata_reg <= {26'h0000000, db_rise_reg};
        cws_pkg::OFS_DB_FALL: rdata_reg <= {26'h0000000, db_fall_reg};
        default: rdata_reg <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  assign avs_readdata = rdata_reg;

  // ********************************************
  // Configuration registers
  // ********************************************
  // enable and pin connects
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      main_ctrl_reg <= cws_pkg::RST_MAIN_CTRL;
    end else if (wr_ok && avs_address == cws_pkg::OFS_MAIN_CTRL) begin
      main_ctrl_reg <= avs_writedata[7:0] & cws_pkg::MASK_MAIN_CTRL;
    end
  end

  // Override levels and input select
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_ovr_reg <= cws_pkg::RST_SRC_OVR;
    end else if (wr_ok && avs_address == cws_pkg::OFS_SRC_OVR) begin
      src_ovr_reg <= avs_writedata[7:0] & cws_pkg::MASK_SRC_OVR;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shdn_ctrl_reg <= cws_pkg::RST_SHDN_CTRL;
    end else if (wr_shdn) begin
      shdn_ctrl_reg <= avs_writedata[7:0] & cws_pkg::MASK_SHDN_CTRL;
    end
  end

  // Dead-band counts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      db_rise_reg <= cws_pkg::RST_DB;
      db_fall_reg <= cws_pkg::RST_DB;
    end else if (wr_ok && avs_address == cws_pkg::OFS_DB_RISE) begin
      db_rise_reg <= avs_writedata[5:0];
    end else if (wr_ok && avs_address == cws_pkg::OFS_DB_FALL) begin
      db_fall_reg <= avs_writedata[5:0];
    end
  end

  // ********************************************
  // Input selection
  // ********************************************
  // source select decode
  always_comb begin
    case (src_ovr_reg[cws_pkg::SO_SRC +: 3])
      3'h7: wave_sel = wave_src.logic_cell1_output;
      3'h6: wave_sel = wave_src.oscillator_output;
      3'h5: wave_sel = wave_src.pwm_output[3];
      3'h4: wave_sel = wave_src.pwm_output[2];
      3'h3: wave_sel = wave_src.pwm_output[1];
      3'h2: wave_sel = wave_src.pwm_output[0];
      3'h1: wave_sel = wave_src.comparator2_output;
      default: wave_sel = wave_src.comparator1_output;
    endcase
  end

  // Previous input for edge detect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wave_prev_reg <= 1'b0;
    end else begin
      wave_prev_reg <= wave_sel;
    end
  end

  assign wave_rise = wave_sel && !wave_prev_reg;

  // ********************************************
  // Shutdown sources
  // ********************************************
  // level sensed sources
  assign src_active = (shdn_ctrl_reg[cws_pkg::SC_CMP2] && fault_src.comparator2_output)
                   || (shdn_ctrl_reg[cws_pkg::SC_CMP1] && fault_src.comparator1_output)
                   || (shdn_ctrl_reg[cws_pkg::SC_FAULT] && !fault_src.fault_input_pin_n)
                   || (shdn_ctrl_reg[cws_pkg::SC_LC2] && fault_src.logic_cell2_output);

  assign shutdown_any = src_active || shutdown_event_reg;

  // Event bit: any set wins over a clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shutdown_event_reg <= 1'b0;
    end else if (src_active || sw_set) begin
      shutdown_event_reg <= 1'b1;
    end else if (auto_restart_enable) begin
      shutdown_event_reg <= 1'b0;
    end else if (sw_clear) begin
      shutdown_event_reg <= 1'b0;
    end
  end

  // hold overrides to next rising edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shut_state_reg <= 1'b0;
    end else if (shutdown_any) begin
      shut_state_reg <= 1'b1;
    end else if (wave_rise) begin
      shut_state_reg <= 1'b0;
    end
  end

  assign force_ovr = shut_state_reg || shutdown_any;

  // ********************************************
  // Waveform and dead band
  // ********************************************
  // runs on clk, no sleep gating
  cws_tick_divider u_tick (
    .clk(clk),
    .reset(reset),
    .use_hf_osc(main_ctrl_reg[cws_pkg::MC_CLK_SEL]),
    .tick(gen_tick)
  );

  // disabled or shut chains stay cleared
  cws_deadband u_db_rise (
    .clk(clk),
    .reset(reset),
    .tick(gen_tick),
    .level(module_enable && !force_ovr && wave_sel),
    .count(db_rise_reg),
    .drive(core_a)
  );

  cws_deadband u_db_fall (
    .clk(clk),
    .reset(reset),
    .tick(gen_tick),
    .level(module_enable && !force_ovr && !wave_sel),
    .count(db_fall_reg),
    .drive(core_b)
  );

  // ********************************************
  // Pin drive
  // ********************************************
  // override codes, polarity
  always_comb begin
    if (force_ovr && override_level_a[1]) begin
      output_a = override_level_a[0];
    end else begin
      output_a = core_a ^ main_ctrl_reg[cws_pkg::MC_INV_A];
    end
    if (force_ovr && override_level_b[1]) begin
      output_b = override_level_b[0];
    end else begin
      output_b = core_b ^ main_ctrl_reg[cws_pkg::MC_INV_B];
    end
  end

  assign output_a_oe = module_enable && main_ctrl_reg[cws_pkg::MC_OE_A]
                    && !(force_ovr && override_level_a == cws_pkg::LVL_TRI);
  assign output_b_oe = module_enable && main_ctrl_reg[cws_pkg::MC_OE_B]
                    && !(force_ovr && override_level_b == cws_pkg::LVL_TRI);

  assign hf_osc_keep_on = module_enable && main_ctrl_reg[cws_pkg::MC_CLK_SEL];

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_sw_sets_event: assert property (sw_set |=> shutdown_event_reg && force_ovr)
    else $error("software shutdown did not take hold");
  a_hold_no_restart: assert property (
    (shutdown_event_reg && !auto_restart_enable && !sw_clear) |=> shutdown_event_reg)
    else $error("event dropped without restart");
  a_auto_self_clear: assert property (
    (shutdown_event_reg && auto_restart_enable && !src_active && !sw_set) |=> !shutdown_event_reg)
    else $error("auto restart did not clear event");
  a_source_forces_out: assert property (
    (src_active && override_level_a[1]) |-> output_a == override_level_a[0])
    else $error("fault did not force output A level");
  a_level_holds_event: assert property (src_active |=> shutdown_event_reg [*1])
    else $error("active source left event clear");
  a_clear_refused: assert property (
    (sw_clear && !auto_restart_enable && src_active) |=> shutdown_event_reg)
    else $error("clear accepted with source active");
  a_override_until_edge: assert property (
    (shut_state_reg && !shutdown_any && !wave_rise) |=> shut_state_reg)
    else $error("override released without rising edge");
  a_disabled_no_pins: assert property (!module_enable |-> !output_a_oe && !output_b_oe)
    else $error("pins driven while disabled");
  a_tristate_code: assert property ((force_ovr && override_level_b == cws_pkg::LVL_TRI) |-> !output_b_oe)
    else $error("tristate override drove pin B");
  a_polarity_a: assert property (
    (!force_ovr && module_enable) |-> output_a == (core_a ^ main_ctrl_reg[cws_pkg::MC_INV_A]))
    else $error("output A polarity wrong");
  a_no_overlap: assert property (!(core_a && core_b))
    else $error("both drives on together");

  c_sw_restart: cover property (shutdown_event_reg ##1 !shutdown_event_reg ##[1:100] !shut_state_reg);
  c_fault_trip: cover property (!shutdown_any ##1 src_active);
  c_auto_restart: cover property (auto_restart_enable && sw_set ##1 shutdown_event_reg ##1 !shutdown_event_reg);
  c_dead_band: cover property (wave_rise && db_rise_reg != 6'h00 ##[1:64] core_a);

endmodule : cws_top
`default_nettype wire

// [sim/cws_switch_model.sv]
// Partner model: power switch gate drivers on pins A and B.
// Assumes each pin is pulled low while the block releases it.
`timescale 1ns/1ps
`default_nettype none
module cws_switch_model (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic output_a, // Pin A level
  input wire logic output_a_oe, // Pin A driven
  input wire logic output_b, // Pin B level
  input wire logic output_b_oe, // Pin B driven
  output logic pin_a, // Gate A seen
  output logic pin_b, // Gate B seen
  output logic both_on // Sticky overlap flag
);
  // Released pin falls to the pull-down level
  assign pin_a = output_a_oe & output_a;
  assign pin_b = output_b_oe & output_b;
  // Overlap of both gates is remembered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      both_on <= 1'b0;
    end else if (pin_a & pin_b) begin
      both_on <= 1'b1;
    end
  end
endmodule : cws_switch_model
`default_nettype wire

// [sim/cws_top_tb.sv]
// Testbench of the waveform shutdown block: register map, shutdown,
// restart, dead band. Assumes the Avalon slave and the pin model.
`timescale 1ns/1ps
`default_nettype none
module cws_top_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  cws_pkg::cws_src_s wave_src;
  cws_pkg::cws_fault_s fault_src;
  logic output_a, output_a_oe, output_b, output_b_oe, hf_osc_keep_on, pin_a, pin_b, both_on;
  logic [7:0] q; // Last read byte
  int error_cnt = 0, checks_done = 0, i, n;
  // Rows: address, write byte, read back
  // Main control is switched off again before the dead bands change, so the pins never overlap
  logic [20:0] rows [11] = '{{5'h00, 8'hFF, 8'hF9}, {5'h00, 8'h00, 8'h00}, {5'h04, 8'hFF, 8'hF7},
    {5'h0C, 8'hFF, 8'h3F}, {5'h10, 8'hAA, 8'h2A}, {5'h14, 8'hFF, 8'h00}, {5'h08, 8'h0F, 8'h0F},
    {5'h04, 8'h00, 8'h00}, {5'h08, 8'h00, 8'h00}, {5'h0C, 8'h00, 8'h00}, {5'h10, 8'h00, 8'h00}};
  cws_top cws_top_inst (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wave_src(wave_src),
    .fault_src(fault_src), .output_a(output_a), .output_a_oe(output_a_oe), .output_b(output_b),
    .output_b_oe(output_b_oe), .hf_osc_keep_on(hf_osc_keep_on));
  cws_switch_model cws_switch_model_inst (.clk(clk), .reset(reset), .output_a(output_a),
    .output_a_oe(output_a_oe), .output_b(output_b), .output_b_oe(output_b_oe), .pin_a(pin_a),
    .pin_b(pin_b), .both_on(both_on));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Avalon access held until waitrequest seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    // Waitrequest is sampled at the rising edge; the access completes there
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      $display("MISMATCH t=%0t bus timeout", $time);
      results();
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Let the registers settle before anyone looks at the outputs
    @(negedge clk);
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  // Pins as {a, b, oe a, oe b}
  task automatic outs(input logic [3:0] e);
    // Overrides drop one edge after the input rise is seen
    @(posedge clk);
    @(negedge clk);
    chk({4'h0, output_a, output_b, output_a_oe, output_b_oe}, {4'h0, e});
  endtask : outs
  task automatic wave(input logic [7:0] v);
    @(posedge clk);
    wave_src <= v;
  endtask : wave
  task automatic flt(input logic [3:0] v);
    @(posedge clk);
    fault_src <= v;
  endtask : flt
  // Input rise, then cycles until A turns on
  task automatic db(input int lo, input int hi);
    wave(8'h00);
    wave(8'h04);
    n = 0;
    @(negedge clk);
    chk({7'h00, output_b}, 8'h00);
    while (output_a !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask : db
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #600000;
    error_cnt++;
    $display("MISMATCH t=%0t run timeout", $time);
    results();
  end
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    wave_src = 8'h00;
    fault_src = 4'h2;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 5; i++) rd(5'(4 * i), 8'h00);
    for (i = 0; i < 11; i++) begin
      wr(rows[i][20:16], rows[i][15:8]);
      rd(rows[i][20:16], rows[i][7:0]);
    end
    $display("done: register map");
    wr(5'h08, 8'h80);
    wr(5'h04, 8'hE2);
    wr(5'h00, 8'hE0);
    outs(4'h7);
    wr(5'h04, 8'h52);
    outs(4'h0);
    wr(5'h04, 8'hE2);
    wave(8'h04);
    repeat (4) @(posedge clk);
    outs(4'h7);
    wr(5'h08, 8'h00);
    rd(5'h08, 8'h00);
    outs(4'h7);
    wave(8'h00);
    wave(8'h04);
    outs(4'hB);
    chk({6'h00, pin_a, pin_b}, 8'h02);
    for (i = 0; i < 8; i++) begin
      wr(5'h04, 8'hE0 | 8'(i));
      wave(8'h01 << i);
      outs(4'hB);
      wave(8'h00);
      outs(4'h7);
    end
    wr(5'h04, 8'hE2);
    wave(8'h04);
    wr(5'h00, 8'hF8);
    outs(4'h7);
    wr(5'h00, 8'hE0);
    outs(4'hB);
    $display("done: software shutdown and sources");
    for (i = 0; i < 4; i++) begin
      flt(4'h2 ^ (4'h1 << i));
      outs(4'hB);
      rd(5'h08, 8'h00);
      flt(4'h2);
      wr(5'h08, 8'h01 << i);
      flt(4'h2 ^ (4'h1 << i));
      outs(4'h7);
      wr(5'h08, 8'h01 << i);
      rd(5'h08, 8'h80 | (8'h01 << i));
      flt(4'h2);
      wr(5'h08, 8'h00);
      rd(5'h08, 8'h00);
      outs(4'h7);
      wave(8'h00);
      wave(8'h04);
      outs(4'hB);
    end
    $display("done: fault sources");
    wr(5'h08, 8'h44);
    flt(4'h6);
    outs(4'h7);
    rd(5'h08, 8'hC4);
    flt(4'h2);
    repeat (3) @(posedge clk);
    rd(5'h08, 8'h44);
    outs(4'h7);
    wave(8'h00);
    wave(8'h04);
    outs(4'hB);
    wr(5'h08, 8'hC0);
    rd(5'h08, 8'h40);
    outs(4'h7);
    wave(8'h00);
    wave(8'h04);
    outs(4'hB);
    wr(5'h08, 8'h00);
    $display("done: auto-restart");
    wr(5'h0C, 8'h03);
    db(2, 4);
    wr(5'h00, 8'hE1);
    chk({7'h00, hf_osc_keep_on}, 8'h01);
    db(8, 28);
    wr(5'h00, 8'h60);
    chk({3'h0, hf_osc_keep_on, output_a_oe, output_b_oe, pin_a, pin_b}, 8'h00);
    chk({7'h00, both_on}, 8'h00);
    $display("done: dead band and disable");
    results();
  end
endmodule : cws_top_tb
`default_nettype wire
